// file: verilog/csgb_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module csgb_buffer
    import csgb_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // static configuration
    input wire csgb_cfg_t cfg_in,
    // clock sources
    input wire logic [PIN_CLK_W-1:0] pin_clk_in,
    input wire logic pll_clk_in,
    input wire logic core_sig_clk_in,
    // dynamic controls
    input wire logic [SEL_W-1:0] sel_in,
    input wire logic ena_in,
    // buffered clock
    output logic clk_out,
    // status
    output csgb_stat_t stat_out,
    output logic [NUM_SRC-1:0] src_alive_out
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [NUM_SRC-1:0] src;
    logic [NUM_SRC-1:0] src_prev;
    logic first_rise;
    logic cfg_err;
    logic eff_ext;
    logic [1:0] eff_cnt;
    logic sel_raw;
    logic [SEL_W-1:0] sel_pin;
    logic [SEL_W-1:0] sel_q;
    logic [SEL_W-1:0] next_sel;
    logic [1:0] req;
    logic gf_eff;
    logic ena_eff;
    logic sw_clk;
    logic [1:0] cur_src;
    logic sw_busy;
    logic [NUM_SRC-1:0] stalled;
    csgb_stat_t next_stat;
    logic [NUM_SRC-1:0] next_src_prev;
    logic [NUM_SRC-1:0] src_chg;
    logic cnt_err;
    logic path_err;
    logic [1:0] sel_src;
    logic sel_ok;
    logic multi_src;
    logic [NUM_SRC-1:0] next_alive;

    ////////////////////////////////////////////////////////////////////////
    // source vector: pins, PLL output, core-made clock

    // bit 0 is the first input clock, codes follow bit order
    always_comb begin
        src[PIN_CLK_W-1:0] = pin_clk_in;
        src[SEL_PLL] = pll_clk_in;
        src[SEL_CORE] = core_sig_clk_in;
    end

    // previous samples for edge detection
    always_comb begin
        next_src_prev = src;
    end

    // no reset: a cleared copy would fake a rise just after release
    always_ff @(posedge core_clk_in) begin
        src_prev <= next_src_prev;
    end

    ////////////////////////////////////////////////////////////////////////
    // per-source edges

    // a change flag a source feeds its activity monitor
    generate
        for (genvar j = 0; j < NUM_SRC; j++) begin : g_edge
            assign src_chg[j] = src[j] ^ src_prev[j];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // configuration check

    // external path takes exactly one clock
    always_comb begin
        cnt_err = (cfg_in.mode == CSGB_MODE_EXT) && (cfg_in.src_cnt != CNT_ONE);
    end

    // external path takes no dynamic select
    always_comb begin
        path_err = (cfg_in.mode == CSGB_MODE_EXT) && cfg_in.sel_used;
    end

    // either fault flags the setup
    always_comb begin
        cfg_err = cnt_err || path_err;
    end

    // a bad external setting falls back to the global network
    always_comb begin
        eff_ext = (cfg_in.mode == CSGB_MODE_EXT) && !cfg_err;
        eff_cnt = eff_ext ? CNT_ONE : cfg_in.src_cnt;
    end

    ////////////////////////////////////////////////////////////////////////
    // source select capture

    // unconnected select reads as code zero
    always_comb begin
        sel_raw = cfg_in.sel_used;
        sel_pin = sel_raw ? sel_in : SEL_RST;
    end

    // a rise of the first input clock is the only capture point
    always_comb begin
        first_rise = src[SEL_PIN0] & ~src_prev[SEL_PIN0];
    end

    // select only moves on a rise of the first input clock
    always_comb begin
        next_sel = sel_q;
        if (first_rise) begin
            next_sel = sel_pin;
        end
    end

    // register captured select, code zero out of reset
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            sel_q <= SEL_RST;
        end else begin
            sel_q <= next_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // select decode

    // code to source: 00 first pin, 01 second pin, 10 PLL, 11 core
    always_comb begin
        case (sel_q)
            SEL_PIN0: sel_src = SEL_PIN0;
            SEL_PIN1: sel_src = SEL_PIN1;
            SEL_PLL: sel_src = SEL_PLL;
            SEL_CORE: sel_src = SEL_CORE;
            default: sel_src = SEL_PIN0;
        endcase
    end

    // a code is usable only within the configured count
    always_comb begin
        sel_ok = (sel_src <= eff_cnt);
    end

    ////////////////////////////////////////////////////////////////////////
    // requested source

    // codes beyond the configured count fall back to clock zero
    always_comb begin
        if (eff_ext) begin
            req = SEL_PLL;
        end else if (!sel_ok) begin
            req = SEL_PIN0;
        end else begin
            req = sel_src;
        end
    end

    // more than one source in use
    always_comb begin
        multi_src = (eff_cnt != CNT_ONE);
    end

    // glitch-free only matters with more than one source
    always_comb begin
        gf_eff = cfg_in.glitch_free && multi_src;
    end

    ////////////////////////////////////////////////////////////////////////
    // source switch

    csgb_switch u_switch (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .src_in(src),
        .src_prev_in(src_prev),
        .req_in(req),
        .gf_in(gf_eff),
        .sw_clk_out(sw_clk),
        .cur_out(cur_src),
        .busy_out(sw_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // network enable

    // unconnected enable reads as high
    always_comb begin
        ena_eff = cfg_in.ena_used ? ena_in : 1'b1;
    end

    // the single buffered output
    csgb_gate u_gate (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .clk_sel_in(sw_clk),
        .ena_in(ena_eff),
        .gclk_out(clk_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // per-source activity monitors

    // a source with no edge for the stall time is flagged stopped
    generate
        for (genvar i = 0; i < NUM_SRC; i++) begin : g_mon
            logic [STALL_W-1:0] cnt;
            logic [STALL_W-1:0] next_cnt;

            // restart on every edge, saturate at the limit
            always_comb begin
                if (src_chg[i]) begin
                    next_cnt = STALL_RST;
                end else if (cnt < STALL_MAX) begin
                    next_cnt = cnt + 7'h01;
                end else begin
                    next_cnt = cnt;
                end
            end

            // register the count
            always_ff @(posedge core_clk_in) begin
                if (srst_in) begin
                    cnt <= STALL_RST;
                end else begin
                    cnt <= next_cnt;
                end
            end

            assign stalled[i] = (cnt == STALL_MAX);
        end
    endgenerate

    // alive means an edge seen within the stall time
    always_comb begin
        next_alive = ~stalled;
    end

    // register alive flags
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            src_alive_out <= '0;
        end else begin
            src_alive_out <= next_alive;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status

    // a stalled current source blocks a pending switch
    always_comb begin
        next_stat.active_src = cur_src;
        next_stat.switching = sw_busy;
        next_stat.cfg_err = cfg_err;
        next_stat.src_stalled = stalled[cur_src];
        next_stat.route_ext = eff_ext;
    end

    // register status
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            stat_out <= STAT_RST;
        end else begin
            stat_out <= next_stat;
        end
    end

endmodule : csgb_buffer
`default_nettype wire

// file: verilog/csgb_pkg.sv
`default_nettype none
package csgb_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths and select codes
    localparam int NUM_SRC = 4;
    localparam int PIN_CLK_W = 2;
    localparam int SEL_W = 2;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [1:0] SEL_PIN0 = 2'h0;
    localparam logic [1:0] SEL_PIN1 = 2'h1;
    localparam logic [1:0] SEL_PLL = 2'h2;
    localparam logic [1:0] SEL_CORE = 2'h3;
    localparam logic [1:0] CNT_ONE = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // timing: a source with no edge for this long counts as stopped
    localparam int CLK_MHZ = 25;
    localparam int STALL_NS = 2000;
    localparam int STALL_CYC = (STALL_NS * CLK_MHZ) / 1000;
    localparam int STALL_W = 7;
    localparam logic [STALL_W-1:0] STALL_MAX = STALL_W'(STALL_CYC);
    localparam logic [STALL_W-1:0] STALL_RST = 7'h00;

    ////////////////////////////////////////////////////////////////////////
    // modes, states and carriers
    typedef enum logic {
        CSGB_MODE_GLOBAL = 1'b0,
        CSGB_MODE_EXT = 1'b1
    } csgb_mode_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_DROP = 2'b01,
        SW_PICK = 2'b10
    } csgb_sw_state_t;

    typedef struct packed {
        csgb_mode_t mode;
        logic [1:0] src_cnt;
        logic glitch_free;
        logic ena_used;
        logic sel_used;
    } csgb_cfg_t;

    typedef struct packed {
        logic [1:0] active_src;
        logic switching;
        logic cfg_err;
        logic src_stalled;
        logic route_ext;
    } csgb_stat_t;

    localparam csgb_stat_t STAT_RST = '0;

endpackage : csgb_pkg
`default_nettype wire

// file: verilog/csgb_gate.sv
`timescale 1ns/10ps
`default_nettype none
module csgb_gate
    import csgb_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // selected clock and enable
    input wire logic clk_sel_in,
    input wire logic ena_in,
    // gated clock
    output logic gclk_out
);

    logic en;
    logic next_en;
    logic next_gclk;

    ////////////////////////////////////////////////////////////////////////
    // enable only moves while the clock is low, output low while disabled
    always_comb begin
        next_en = clk_sel_in ? en : ena_in;
        next_gclk = clk_sel_in & next_en;
    end

    // register enable and output
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            en <= 1'b0;
            gclk_out <= 1'b0;
        end else begin
            en <= next_en;
            gclk_out <= next_gclk;
        end
    end

endmodule : csgb_gate
`default_nettype wire

// file: verilog/csgb_switch.sv
`timescale 1ns/10ps
`default_nettype none
module csgb_switch
    import csgb_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // sampled sources and their previous samples
    input wire logic [NUM_SRC-1:0] src_in,
    input wire logic [NUM_SRC-1:0] src_prev_in,
    // requested source and mode
    input wire logic [1:0] req_in,
    input wire logic gf_in,
    // switched clock and state
    output logic sw_clk_out,
    output logic [1:0] cur_out,
    output logic busy_out
);

    csgb_sw_state_t state;
    csgb_sw_state_t next_state;
    logic [1:0] tgt;
    logic [1:0] next_tgt;
    logic [1:0] next_cur;
    logic next_sw_clk;
    logic old_fall;
    logic new_fall;

    ////////////////////////////////////////////////////////////////////////
    // switch sequencer: drop old on its fall, take new on its fall
    always_comb begin
        next_state = state;
        next_cur = cur_out;
        next_tgt = tgt;
        old_fall = src_prev_in[cur_out] & ~src_in[cur_out];
        new_fall = src_prev_in[tgt] & ~src_in[tgt];
        case (state)
            SW_IDLE: begin
                if (req_in != cur_out) begin
                    if (gf_in) begin
                        next_tgt = req_in;
                        next_state = SW_DROP;
                    end else begin
                        next_cur = req_in;
                    end
                end
            end
            SW_DROP: begin
                if (old_fall) begin
                    next_state = SW_PICK;
                end
            end
            SW_PICK: begin
                if (new_fall) begin
                    next_cur = tgt;
                    next_state = SW_IDLE;
                end
            end
            default: begin
                next_state = SW_IDLE;
            end
        endcase
        // output held low between the two falling edges
        case (next_state)
            SW_IDLE: next_sw_clk = src_in[next_cur];
            SW_DROP: next_sw_clk = src_in[cur_out];
            default: next_sw_clk = 1'b0;
        endcase
    end

    // register sequencer state
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            state <= SW_IDLE;
            cur_out <= SEL_RST;
            tgt <= SEL_RST;
            sw_clk_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            state <= next_state;
            cur_out <= next_cur;
            tgt <= next_tgt;
            sw_clk_out <= next_sw_clk;
            busy_out <= (next_state != SW_IDLE);
        end
    end

endmodule : csgb_switch
`default_nettype wire

// file: dv/csgb_buffer_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module csgb_buffer_assertions
    import csgb_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // watched inputs
    input wire csgb_cfg_t cfg_in,
    input wire logic [PIN_CLK_W-1:0] pin_clk_in,
    input wire logic pll_clk_in,
    input wire logic core_sig_clk_in,
    input wire logic [SEL_W-1:0] sel_in,
    input wire logic ena_in,
    // watched outputs
    input wire logic clk_out,
    input wire csgb_stat_t stat_out,
    input wire logic [NUM_SRC-1:0] src_alive_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (srst_in);

    logic en_eff;
    logic en_q;
    logic pin0_q;
    logic ext_ok;
    logic ext_bad;
    logic glb_nosel;
    logic [4:0] en_cnt;
    logic [4:0] since0;

    ////////////////////////////////////////////////////////////////////////
    // effective enable and external-mode legality
    assign en_eff = !cfg_in.ena_used || ena_in;
    assign ext_ok = cfg_in.mode == CSGB_MODE_EXT && cfg_in.src_cnt == CNT_ONE && !cfg_in.sel_used;
    assign ext_bad = cfg_in.mode == CSGB_MODE_EXT && !ext_ok;
    assign glb_nosel = cfg_in.mode == CSGB_MODE_GLOBAL && !cfg_in.sel_used && !cfg_in.glitch_free;

    // age of the enable level and of the last first-clock rise
    always_ff @(posedge core_clk_in) begin
        en_q <= en_eff;
        pin0_q <= pin_clk_in[0];
        if (srst_in) begin
            en_cnt <= 5'h00;
            since0 <= 5'h1F;
        end else begin
            en_cnt <= (en_eff != en_q) ? 5'h00 : en_cnt + 5'(en_cnt != 5'h1F);
            since0 <= (pin_clk_in[0] && !pin0_q) ? 5'h00 : since0 + 5'(since0 != 5'h1F);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    reset_clears_a: assert property (disable iff (1'b0) srst_in |=>
        !clk_out && stat_out == STAT_RST && src_alive_out == '0) else $error("reset not clean");
    gate_low_a: assert property (!en_eff && en_cnt >= 5'h0C |-> !clk_out)
        else $error("clock passes while disabled");
    ena_open_a: assert property (en_eff && en_cnt >= 5'h10 && src_alive_out == 4'hF
        && !cfg_in.glitch_free |-> ##[0:12] clk_out) else $error("clock blocked");
    ext_route_a: assert property (ext_ok [*3] |-> stat_out.route_ext && !stat_out.cfg_err)
        else $error("external path not taken");
    ext_source_a: assert property (ext_ok [*3] |-> ##[0:20] stat_out.active_src == SEL_PLL)
        else $error("external path not on pll");
    cfg_error_a: assert property (ext_bad [*3] |-> stat_out.cfg_err && !stat_out.route_ext)
        else $error("bad external setup accepted");
    sel_unused_a: assert property (glb_nosel [*3] |-> ##[0:20] stat_out.active_src == SEL_PIN0)
        else $error("unconnected select not zero");
    capture_rise_a: assert property (cfg_in.mode == CSGB_MODE_GLOBAL && !cfg_in.glitch_free
        && $changed(stat_out.active_src) |-> since0 == 5'h02) else $error("switch without capture");
    no_runt_a: assert property (cfg_in.glitch_free && $rose(clk_out) |=> clk_out)
        else $error("runt pulse");

    // main scenarios
    cover property (stat_out.switching);
    cover property (stat_out.cfg_err);
    cover property (stat_out.route_ext);
endmodule : csgb_buffer_assertions

bind csgb_buffer csgb_buffer_assertions u_chk (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .cfg_in(cfg_in), .pin_clk_in(pin_clk_in), .pll_clk_in(pll_clk_in),
    .core_sig_clk_in(core_sig_clk_in), .sel_in(sel_in), .ena_in(ena_in), .clk_out(clk_out),
    .stat_out(stat_out), .src_alive_out(src_alive_out));
`default_nettype wire

// file: dv/csgb_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module csgb_src_model
    import csgb_pkg::*;
(
    // clock
    input wire logic core_clk_in,
    // run control, one bit a source
    input wire logic [NUM_SRC-1:0] run_in,
    // source clocks
    output logic [NUM_SRC-1:0] src_out
);
    ////////////////////////////////////////////////////////////////////////
    // source i toggles every i+2 cycles; a stop waits for the low phase
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        logic [2:0] cnt = 3'h0;
        logic q = 1'b0;
        assign src_out[i] = q;
        always @(posedge core_clk_in) begin
            if (!run_in[i] && !q) begin
                cnt <= 3'h0;
            end else if (cnt == 3'(i + 1)) begin
                q <= !q;
                cnt <= 3'h0;
            end else begin
                cnt <= cnt + 3'h1;
            end
        end
    end
endmodule : csgb_src_model
`default_nettype wire

// file: dv/csgb_buffer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module csgb_buffer_tb_top
    import csgb_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic srst_in = 1'b1;
    csgb_cfg_t cfg = '0;
    logic [1:0] sel = 2'h0;
    logic ena = 1'b1;
    logic [3:0] run = 4'hF;
    logic [3:0] src;
    logic clk_out;
    csgb_stat_t stat_out;
    logic [3:0] alive;
    int fail_count = 0;
    int checked = 0;

    // clock, sources and device
    always #20 core_clk_in = !core_clk_in;
    csgb_src_model u_src (.core_clk_in(core_clk_in), .run_in(run), .src_out(src));
    csgb_buffer dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .cfg_in(cfg),
        .pin_clk_in(src[1:0]), .pll_clk_in(src[2]), .core_sig_clk_in(src[3]), .sel_in(sel),
        .ena_in(ena), .clk_out(clk_out), .stat_out(stat_out), .src_alive_out(alive));

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
        input logic [15:0] tol = 16'h0);
        checked++;
        if (((got + tol >= exp) && (got <= exp + tol)) !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    // reset with a new static setup, outputs must be clear
    task automatic setup(input csgb_cfg_t c, input logic [1:0] s, input logic e);
        @(posedge core_clk_in);
        srst_in <= 1'b1;
        cfg <= c;
        sel <= s;
        ena <= e;
        repeat (6) @(posedge core_clk_in);
        srst_in <= 1'b0;
        @(negedge core_clk_in);
        check(16'({clk_out, alive, stat_out}), 16'h0);
    endtask : setup

    task automatic wait_active(input logic [1:0] code);
        int i;
        for (i = 0; i < 400 && stat_out.active_src !== code; i++) begin
            @(negedge core_clk_in);
        end
        if (i == 400) begin
            check(16'(stat_out.active_src), 16'(code));
            conclude();
        end
    endtask : wait_active

    // count output rises over a window against the source's period
    task automatic expect_src(input logic [1:0] code, input logic en);
        int n;
        logic prev;
        wait_active(code);
        n = 0;
        prev = clk_out;
        repeat (120) begin
            @(negedge core_clk_in);
            if (clk_out === 1'b1 && prev !== 1'b1) begin
                n++;
            end
            prev = clk_out;
        end
        check(16'(n), en ? 16'(120 / (2 * (int'(code) + 2))) : 16'h0, 16'h1);
    endtask : expect_src

    ////////////////////////////////////////////////////////////////////////
    initial begin
        setup('{CSGB_MODE_GLOBAL, 2'h3, 1'b0, 1'b1, 1'b1}, 2'h0, 1'b1);
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk_in);
            sel <= 2'(k);
            expect_src(2'(k), 1'b1);
        end
        @(posedge core_clk_in);
        ena <= 1'b0;
        expect_src(2'h3, 1'b0);
        @(posedge core_clk_in);
        ena <= 1'b1;
        expect_src(2'h3, 1'b1);
        @(posedge core_clk_in);
        run <= 4'hE;
        repeat (4) @(posedge core_clk_in);
        sel <= 2'h1;
        repeat (100) @(negedge core_clk_in);
        check(16'({stat_out.active_src, alive}), 16'h3E);
        @(posedge core_clk_in);
        run <= 4'hF;
        expect_src(2'h1, 1'b1);
        setup('{CSGB_MODE_GLOBAL, 2'h1, 1'b0, 1'b1, 1'b1}, 2'h1, 1'b1);
        expect_src(2'h1, 1'b1);
        @(posedge core_clk_in);
        sel <= 2'h3;
        expect_src(2'h0, 1'b1);
        setup('{CSGB_MODE_GLOBAL, 2'h3, 1'b0, 1'b0, 1'b0}, 2'h3, 1'b0);
        repeat (40) @(negedge core_clk_in);
        check(16'(stat_out.active_src), 16'h0);
        expect_src(2'h0, 1'b1);
        setup('{CSGB_MODE_EXT, 2'h0, 1'b0, 1'b1, 1'b0}, 2'h0, 1'b1);
        expect_src(SEL_PLL, 1'b1);
        check(16'({stat_out.cfg_err, stat_out.route_ext}), 16'h1);
        setup('{CSGB_MODE_EXT, 2'h3, 1'b0, 1'b1, 1'b1}, 2'h0, 1'b1);
        @(posedge core_clk_in);
        sel <= 2'h1;
        expect_src(2'h1, 1'b1);
        check(16'({stat_out.cfg_err, stat_out.route_ext}), 16'h2);
        setup('{CSGB_MODE_GLOBAL, 2'h3, 1'b1, 1'b1, 1'b1}, 2'h2, 1'b1);
        expect_src(SEL_PLL, 1'b1);
        @(posedge core_clk_in);
        run <= 4'hB;
        repeat (20) @(posedge core_clk_in);
        sel <= 2'h1;
        repeat (100) @(negedge core_clk_in);
        check(16'({stat_out.active_src, stat_out.switching, stat_out.src_stalled, alive}),
            16'hBB);
        @(posedge core_clk_in);
        run <= 4'hF;
        expect_src(2'h1, 1'b1);
        conclude();
    end
endmodule : csgb_buffer_tb_top
`default_nettype wire
